/* File: verilog/acq_pkg.sv */
/*
 * Shared constants and types for the digitizer acquisition path:
 * stream widths, minimum record size, downconverter ranges, CORDIC table.
 * Assumes a single 125 MHz sample-logic clock.
 */
package acq_pkg;

    localparam int          ADC_W        = 14;
    localparam int          HALF_W       = 16;
    localparam int          WORD_W       = 32;
    localparam int          ACC_W        = 40;
    localparam int          LO_W         = 10;
    localparam int          CORDIC_W     = 22;
    localparam int          CORDIC_ITERS = 8;
    localparam logic [2:0]  CORDIC_LAST  = 3'h3;
    localparam int          MIN_BUFFER   = 256;
    localparam logic [14:0] DECIM_MIN    = 15'h0004;
    localparam logic [14:0] DECIM_MAX    = 15'h4000;
    localparam logic [15:0] PHASE_HALF   = 16'h8000;

    typedef enum logic [1:0] {MODE_IQ, MODE_PM, MODE_FM} out_mode_t;
    typedef enum {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_DONE} acq_state_t;

    // Angle units: one turn is 2^16
    localparam logic [15:0] ATAN_TAB [CORDIC_ITERS] = '{
        16'h2000, 16'h12e4, 16'h09fb, 16'h0511, 16'h028b, 16'h0146, 16'h00a3, 16'h0051};

    // Half-wave of a 16-step sine, amplitude 511
    localparam logic [9:0] SINE_TAB [8] = '{
        10'h000, 10'h0c4, 10'h169, 10'h1d8, 10'h1ff, 10'h1d8, 10'h169, 10'h0c4};

    function automatic logic signed [LO_W-1:0] lo_wave(input logic [3:0] k);
        logic [9:0] m;
        m = SINE_TAB[k[2:0]];
        return k[3] ? -$signed(m) : $signed(m);
    endfunction

endpackage

/* File: verilog/sample_memory.sv */
/*
 * Onboard sample buffer: one write port, one read port with registered data.
 * Assumes both ports share the acquisition clock and clock enable.
 */
`timescale 1ns/1ps
module sample_memory #(
    parameter int AW = 24,
    parameter int DW = 32
) (
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    input  wire logic          i_wr_en,
    input  wire logic [AW-1:0] i_wr_addr,
    input  wire logic [DW-1:0] i_wr_data,
    input  wire logic [AW-1:0] i_rd_addr,
    output logic      [DW-1:0] o_rd_data
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_ce && i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rd_data <= mem[i_rd_addr];
        end
    end

endmodule

/* File: verilog/digitizer_acquisition_path.sv */
/*
 * Digital acquisition path: keep-one-in-n, optional digital_downconverter
 * (mixer, boxcar lowpass + decimator, CORDIC phase/magnitude, FM), and a
 * circular record buffer with pretrigger/posttrigger control.
 * Assumes ADC words arrive on i_clk with a valid strobe at the full rate;
 * external_trigger_input is asynchronous.
 */
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Every converter word is taken at full rate; slower rates are made only here.
// [RULE_02] Below full rate exactly one sample of every n consecutive ones is kept.
// [RULE_03] A configuration bit routes samples to memory directly or via the downconverter.
// [RULE_04] The downconverter first mixes samples with a quadrature local oscillator.
// [RULE_05] After mixing, the rate is reduced by an integer factor from 4 to 16384 inclusive.
// [RULE_06] A programmable lowpass filter precedes the decimation to stop aliasing.
// [RULE_07] Decimated output is either an I/Q pair or a phase/magnitude pair per sample.
// [RULE_08] A selectable discriminator outputs the sample-to-sample phase difference.
// [RULE_09] Each record captures at least the minimum buffer of 256 samples.
// [RULE_10] Only the requested number of points is reported for return to the host.
// [RULE_11] Before the trigger samples overwrite a circular region continuously.
// [RULE_12] After the trigger storing goes on for the posttrigger count; zero ends at trigger.
// [RULE_13] Pre and posttrigger counts reach full memory capacity with no smaller limit.
// [RULE_14] External triggers arrive on the dedicated external trigger input line.
// [RULE_15] A software trigger from the control side is accepted as well.
// [RULE_16] The write position at which the trigger was accepted is recorded.
// [RULE_17] The external trigger is synchronised and edge-detected, accepted at most once.
module digitizer_acquisition_path
    import acq_pkg::*;
#(
    parameter int AW = 24
) (
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    input  wire logic                i_ce,
    input  wire logic                i_adc_valid,
    input  wire logic [ADC_W-1:0]    i_adc_data,
    input  wire logic                i_external_trigger_input,
    input  wire logic                i_sw_trigger,
    input  wire logic                i_arm,
    input  wire logic [15:0]         i_keep_n,
    input  wire logic                i_ddc_enable,
    input  wire logic [31:0]         i_lo_step,
    input  wire logic [14:0]         i_decim,
    input  wire logic [5:0]          i_filt_shift,
    input  wire logic [1:0]          i_out_mode,
    input  wire logic [AW:0]         i_pre_count,
    input  wire logic [AW:0]         i_post_count,
    input  wire logic [AW:0]         i_req_points,
    input  wire logic [AW-1:0]       i_rd_addr,
    output logic      [WORD_W-1:0]   o_rd_data,
    output logic                     o_busy,
    output logic                     o_done,
    output logic      [AW-1:0]       o_trig_addr,
    output logic      [AW:0]         o_captured,
    output logic      [AW:0]         o_ret_points
);

    localparam logic [AW:0] DEPTH   = (AW+1)'(2**AW);
    localparam logic [AW:0] MIN_BUF = (AW+1)'(MIN_BUFFER);

    ////////////////////////////////////////////////////////////////////////////
    // Keep one in n

    logic [15:0]       keep_cnt_r;
    logic              keep_stb_r;
    logic [ADC_W-1:0]  keep_data_r;

    // Converter runs free; every valid word advances the counter
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            keep_cnt_r <= 16'h0000;
            keep_stb_r <= 1'b0;
            keep_data_r <= '0;
        end else if (i_ce) begin
            keep_stb_r <= i_adc_valid && keep_cnt_r == 16'h0000;  // see [RULE_01]
            if (i_adc_valid) begin
                keep_data_r <= i_adc_data;
                keep_cnt_r <= (keep_cnt_r + 16'h0001 >= i_keep_n) ? 16'h0000
                            : keep_cnt_r + 16'h0001;               // see [RULE_02]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Quadrature mixer

    logic [31:0]                 phase_r;
    logic                        mix_stb_r;
    logic signed [ADC_W+LO_W-1:0] mix_i_r;
    logic signed [ADC_W+LO_W-1:0] mix_q_r;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_r <= 32'h0000_0000;
            mix_stb_r <= 1'b0;
            mix_i_r <= '0;
            mix_q_r <= '0;
        end else if (i_ce) begin
            mix_stb_r <= keep_stb_r && i_ddc_enable;
            if (keep_stb_r && i_ddc_enable) begin
                phase_r <= phase_r + i_lo_step;                     // see [RULE_04]
                mix_i_r <= $signed(keep_data_r) * lo_wave(phase_r[31:28] + 4'h4);
                mix_q_r <= -($signed(keep_data_r) * lo_wave(phase_r[31:28]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Boxcar lowpass and decimator

    logic [14:0]              decim_eff;
    logic [14:0]              dec_cnt_r;
    logic signed [ACC_W-1:0]  acc_i_r;
    logic signed [ACC_W-1:0]  acc_q_r;
    logic signed [ACC_W-1:0]  sum_i;
    logic signed [ACC_W-1:0]  sum_q;
    logic                     dump_stb_r;
    logic signed [HALF_W-1:0] dec_i_r;
    logic signed [HALF_W-1:0] dec_q_r;

    assign decim_eff = (i_decim < DECIM_MIN) ? DECIM_MIN
                     : (i_decim > DECIM_MAX) ? DECIM_MAX : i_decim;  // see [RULE_05]
    assign sum_i = acc_i_r + ACC_W'(mix_i_r);
    assign sum_q = acc_q_r + ACC_W'(mix_q_r);

    // Boxcar sum of decim samples is a lowpass with nulls on every alias band
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dec_cnt_r <= 15'h0000;
            acc_i_r <= '0;
            acc_q_r <= '0;
            dump_stb_r <= 1'b0;
            dec_i_r <= '0;
            dec_q_r <= '0;
        end else if (i_ce) begin
            dump_stb_r <= 1'b0;
            if (mix_stb_r) begin
                if (dec_cnt_r + 15'h0001 >= decim_eff) begin
                    dec_cnt_r <= 15'h0000;
                    acc_i_r <= '0;
                    acc_q_r <= '0;
                    dump_stb_r <= 1'b1;
                    dec_i_r <= HALF_W'(sum_i >>> i_filt_shift);      // see [RULE_06]
                    dec_q_r <= HALF_W'(sum_q >>> i_filt_shift);
                end else begin
                    dec_cnt_r <= dec_cnt_r + 15'h0001;
                    acc_i_r <= sum_i;
                    acc_q_r <= sum_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CORDIC vectoring, two iterations per cycle

    logic                       cor_busy_r;
    logic [2:0]                 cor_it_r;
    logic signed [CORDIC_W-1:0] cx_r;
    logic signed [CORDIC_W-1:0] cy_r;
    logic [15:0]                cz_r;
    logic signed [CORDIC_W-1:0] cx_nxt;
    logic signed [CORDIC_W-1:0] cy_nxt;
    logic [15:0]                cz_nxt;
    logic [15:0]                last_phase_r;
    logic                       pm_stb_r;
    logic [WORD_W-1:0]          pm_word_r;

    always_comb begin
        int idx;
        logic signed [CORDIC_W-1:0] tx;
        idx = 0;
        tx = '0;
        cx_nxt = cx_r;
        cy_nxt = cy_r;
        cz_nxt = cz_r;
        for (int k = 0; k < 2; k++) begin
            idx = 2 * int'(cor_it_r) + k;
            tx = cx_nxt;
            if (!cy_nxt[CORDIC_W-1]) begin
                cx_nxt = cx_nxt + (cy_nxt >>> idx);
                cy_nxt = cy_nxt - (tx >>> idx);
                cz_nxt = cz_nxt + ATAN_TAB[idx];
            end else begin
                cx_nxt = cx_nxt - (cy_nxt >>> idx);
                cy_nxt = cy_nxt + (tx >>> idx);
                cz_nxt = cz_nxt - ATAN_TAB[idx];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cor_busy_r <= 1'b0;
            cor_it_r <= 3'h0;
            cx_r <= '0;
            cy_r <= '0;
            cz_r <= 16'h0000;
            last_phase_r <= 16'h0000;
            pm_stb_r <= 1'b0;
            pm_word_r <= '0;
        end else if (i_ce) begin
            pm_stb_r <= 1'b0;
            if (cor_busy_r) begin
                cx_r <= cx_nxt;
                cy_r <= cy_nxt;
                cz_r <= cz_nxt;
                cor_it_r <= cor_it_r + 3'h1;
                if (cor_it_r == CORDIC_LAST) begin
                    cor_busy_r <= 1'b0;
                    pm_stb_r <= 1'b1;
                    last_phase_r <= cz_nxt;
                    if (out_mode_t'(i_out_mode) == MODE_FM) begin
                        pm_word_r <= {cz_nxt - last_phase_r, cx_nxt[HALF_W:1]};  // see [RULE_08]
                    end else begin
                        pm_word_r <= {cz_nxt, cx_nxt[HALF_W:1]};  // see [RULE_07]
                    end
                end
            end
            // At decimation 4 a dump lands on the last iteration; placed last so the load wins
            if (dump_stb_r && out_mode_t'(i_out_mode) != MODE_IQ) begin
                cor_busy_r <= 1'b1;
                cor_it_r <= 3'h0;
                // Fold left half plane onto the right; CORDIC converges there only
                cx_r <= dec_i_r[HALF_W-1] ? -CORDIC_W'(dec_i_r) : CORDIC_W'(dec_i_r);
                cy_r <= dec_i_r[HALF_W-1] ? -CORDIC_W'(dec_q_r) : CORDIC_W'(dec_q_r);
                cz_r <= dec_i_r[HALF_W-1] ? PHASE_HALF : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Path select

    logic              st_stb;
    logic [WORD_W-1:0] st_data;

    always_comb begin
        if (!i_ddc_enable) begin                                     // see [RULE_03]
            st_stb = keep_stb_r;
            st_data = WORD_W'($signed(keep_data_r));
        end else if (out_mode_t'(i_out_mode) == MODE_IQ) begin       // see [RULE_07]
            st_stb = dump_stb_r;
            st_data = {dec_i_r, dec_q_r};
        end else begin
            st_stb = pm_stb_r;
            st_data = pm_word_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger sources

    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic trig_evt;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else if (i_ce) begin
            ext_s1_r <= i_external_trigger_input;                    // see [RULE_14]
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign trig_evt = (ext_s2_r && !ext_s3_r) || i_sw_trigger;      // see [RULE_17] [RULE_15]

    ////////////////////////////////////////////////////////////////////////////
    // Record control

    acq_state_t  state_r;
    logic [AW-1:0] wr_addr_r;
    logic [AW:0]   pre_cnt_r;
    logic [AW:0]   post_cnt_r;
    logic [AW:0]   pre_req;
    logic [AW:0]   post_req;
    logic [AW:0]   pre_need;
    logic          storing;
    logic          trig_ok;
    logic [AW+1:0] rec_sum;
    logic [AW:0]   rec_len;

    // Oversized requests clamp to the whole memory, never lower
    assign pre_req  = (i_pre_count > DEPTH) ? DEPTH : i_pre_count;   // see [RULE_13]
    assign post_req = (i_post_count > DEPTH) ? DEPTH : i_post_count;
    assign pre_need = (post_req >= MIN_BUF || pre_req >= MIN_BUF - post_req) ? pre_req
                    : MIN_BUF - post_req;                            // see [RULE_09]
    assign storing  = st_stb && (state_r == ST_PRE || state_r == ST_ARMED
                                 || state_r == ST_POST);
    assign trig_ok  = state_r == ST_ARMED && trig_evt;
    // Pre plus post may exceed the memory; only one memory's worth is kept
    assign rec_sum  = {1'b0, pre_cnt_r} + {1'b0, post_req};
    assign rec_len  = (rec_sum > {1'b0, DEPTH}) ? DEPTH : rec_sum[AW:0];

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= ST_IDLE;
            wr_addr_r <= '0;
            pre_cnt_r <= '0;
            post_cnt_r <= '0;
        end else if (i_ce) begin
            if (storing) begin
                wr_addr_r <= wr_addr_r + AW'(1);                    // see [RULE_11]
            end
            case (state_r)
                ST_IDLE, ST_DONE: begin
                    if (i_arm) begin
                        state_r <= ST_PRE;
                        pre_cnt_r <= '0;
                        post_cnt_r <= '0;
                    end
                end
                ST_PRE: begin
                    if (pre_cnt_r >= pre_need) begin
                        state_r <= ST_ARMED;
                    end else if (storing) begin
                        pre_cnt_r <= pre_cnt_r + (AW+1)'(1);
                    end
                end
                ST_ARMED: begin
                    if (trig_ok) begin
                        state_r <= (post_req == '0) ? ST_DONE : ST_POST;  // see [RULE_12]
                    end
                end
                ST_POST: begin
                    if (storing) begin
                        post_cnt_r <= post_cnt_r + (AW+1)'(1);
                        if (post_cnt_r + (AW+1)'(1) >= post_req) begin
                            state_r <= ST_DONE;                    // see [RULE_12]
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_trig_addr <= '0;
            o_captured <= '0;
            o_ret_points <= '0;
        end else if (i_ce) begin
            o_busy <= state_r == ST_PRE || state_r == ST_ARMED || state_r == ST_POST;
            o_done <= state_r == ST_DONE;
            if (trig_ok) begin
                o_trig_addr <= wr_addr_r;                            // see [RULE_16]
                o_captured <= rec_len;
                o_ret_points <= (i_req_points < rec_len) ? i_req_points
                              : rec_len;                             // see [RULE_10]
            end
        end
    end

    sample_memory #(.AW(AW), .DW(WORD_W)) u_mem (
        .i_clk     (i_clk),
        .i_ce      (i_ce),
        .i_wr_en   (storing),
        .i_wr_addr (wr_addr_r),
        .i_wr_data (st_data),
        .i_rd_addr (i_rd_addr),
        .o_rd_data (o_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset || !i_ce);

    sequence s_cordic_start;
        dump_stb_r && out_mode_t'(i_out_mode) != MODE_IQ;
    endsequence

    chk_keep_phase: assert property (keep_stb_r |-> $past(keep_cnt_r) == 16'h0000) // [RULE_02]
        else $error("kept sample not at group start");
    chk_path_bypass: assert property (!i_ddc_enable |-> st_stb == keep_stb_r)      // [RULE_03]
        else $error("bypass path does not follow kept samples");
    chk_decim_range: assert property (decim_eff >= DECIM_MIN && decim_eff <= DECIM_MAX) // [RULE_05]
        else $error("decimation factor out of range");
    chk_cordic_len: assert property (s_cordic_start ##1 cor_busy_r[*4] |=> pm_stb_r) // [RULE_07]
        else $error("phase result not ready after four cycles");
    chk_min_record: assert property (trig_ok |-> rec_len >= MIN_BUF)  // [RULE_09]
        else $error("record shorter than minimum buffer");
    chk_zero_post: assert property (trig_ok && post_req == '0 |=> state_r == ST_DONE) // [RULE_12]
        else $error("zero posttrigger did not end at trigger");
    chk_trig_addr: assert property (trig_ok |=> o_trig_addr == $past(wr_addr_r))   // [RULE_16]
        else $error("trigger position not recorded");
    chk_trig_edge: assert property (ext_s2_r ##1 ext_s2_r && !i_sw_trigger |-> !trig_evt) // [RULE_17]
        else $error("held external trigger accepted twice");

endmodule

/* File: verification/adc_source.sv */
/*
 * Converter model: ramp words, one per clock or one every other clock.
 * Assumes it shares the acquisition clock and reset.
 */
`timescale 1ns/1ps
module adc_source (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_slow,
    output logic             o_valid = 1'b0,
    output logic [13:0]      o_data = 14'h0000
);
    logic [13:0] ramp_r = 14'h0000;
    logic        ph_r = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Ramp keeps kept-sample spacing visible in memory
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            ramp_r  <= 14'h0000;
        end else begin
            ph_r <= ~ph_r;
            if (!i_slow || ph_r) begin
                o_valid <= 1'b1;
                o_data  <= ramp_r;
                ramp_r  <= ramp_r + 14'h0001;
            end else begin
                // Idle word never repeats the last one
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the acquisition path: records in bypass and
 * downconverter modes, software and external triggers.
 * Assumes AW is set to 10 so that records stay short.
 */
`timescale 1ns/1ps
module tb_top;
    import acq_pkg::*;
    localparam int AWS = 10;
    localparam int MEM = 1 << AWS;
    logic           clk = 1'b0, rst = 1'b1, sw = 1'b0, arm = 1'b0, ext = 1'b0;
    logic           ddc = 1'b0, slow = 1'b0, adc_valid, busy, done;
    logic [13:0]    adc_data;
    logic [15:0]    keep_n = 16'h0001;
    logic [31:0]    lo_step = 32'h0000_0000, rd_data;
    logic [14:0]    decim = 15'h0004;
    logic [5:0]     fshift = 6'h00;
    logic [1:0]     out_mode = 2'h0;
    logic [AWS:0]   pre_c = '0, post_c = '0, req_c = '0, captured, ret;
    logic [AWS-1:0] rd_addr = '0, trig_addr;
    int             mismatches = 0;
    int             num_checks = 0;
    int             tbl [10][9] = '{
        '{1, 300, 100, 10, 0, 0, 4, 0, 0}, '{3, 100, 0, 2000, 0, 0, 4, 0, 0},
        '{2, 300, 50, 20, 1, 0, 4, 0, 0}, '{1, 100, 80, 30, 1, 0, 4, 0, 0},
        '{1, 1024, 1024, 5, 0, 0, 4, 0, 0}, '{1, 0, 200, 40, 0, 0, 4, 0, 1},
        '{1, 10, 20, 5, 0, 1, 4, 0, 0}, '{1, 10, 20, 5, 0, 1, 4, 1, 0},
        '{1, 10, 20, 5, 0, 1, 4, 2, 0}, '{1, 10, 10, 5, 0, 1, 64, 0, 0}};

    adc_source adc_source_inst (.i_clk(clk), .i_reset(rst), .i_slow(slow),
        .o_valid(adc_valid), .o_data(adc_data));

    digitizer_acquisition_path #(.AW(AWS)) digitizer_acquisition_path_inst (
        .i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_adc_valid(adc_valid),
        .i_adc_data(adc_data), .i_external_trigger_input(ext), .i_sw_trigger(sw),
        .i_arm(arm), .i_keep_n(keep_n), .i_ddc_enable(ddc), .i_lo_step(lo_step),
        .i_decim(decim), .i_filt_shift(fshift), .i_out_mode(out_mode),
        .i_pre_count(pre_c), .i_post_count(post_c), .i_req_points(req_c),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_busy(busy), .o_done(done),
        .o_trig_addr(trig_addr), .o_captured(captured), .o_ret_points(ret));

    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic rd(input int a, output logic [31:0] v);
        @(posedge clk);
        rd_addr <= a[AWS-1:0];
        repeat (2) @(posedge clk);
        #1 v = rd_data;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // One record; model predicts sizes and timing from counts and rates
    task automatic run(input int r[9]);
        int          per, pn, t, ex, cyc, lo, hi, kmax;
        logic [31:0] a, b;
        per = r[8] ? 2 : 1;
        per = per * (r[5] ? r[6] : r[0]);
        pn = (r[1] > 256 - r[2]) ? r[1] : 256 - r[2];
        @(posedge clk);
        keep_n   <= r[0][15:0];
        post_c   <= r[2][AWS:0];
        pre_c    <= r[1][AWS:0];
        req_c    <= r[3][AWS:0];
        ddc      <= r[5][0];
        decim    <= r[6][14:0];
        out_mode <= r[7][1:0];
        slow     <= r[8][0];
        lo_step  <= $urandom;
        fshift   <= 6'($urandom_range(0, 4));
        arm      <= 1'b1;
        @(posedge clk) arm <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("busy", busy, 1);
        t = pn * per + 60;
        repeat (t) @(posedge clk);
        if (r[4] == 0) begin
            sw <= 1'b1;
            @(posedge clk) sw <= 1'b0;
        end else begin
            if (ext) begin
                // Pin still high from last record: no new edge
                repeat (100) @(posedge clk);
                #1 chk("no_retrigger", done, 0);
                @(posedge clk) ext <= 1'b0;
                repeat (4) @(posedge clk);
            end
            ext <= 1'b1;
        end
        cyc = 0;
        while (done !== 1'b1 && cyc < 40000) begin
            @(posedge clk);
            #1 cyc++;
        end
        lo = r[2] * per - (r[5] ? r[6] : 0);
        hi = lo + (r[5] ? 2 * r[6] : 0) + 12;
        chk("done_time", 32'(cyc >= lo && cyc <= hi), 1);
        // Pretrigger fill stops at its need; at most one memory's worth is kept
        ex = (pn + r[2] < MEM) ? pn + r[2] : MEM;
        chk("captured", captured, ex);
        chk("min_record", 32'(captured >= 256), 1);
        if (r[3] < 256)
            chk("ret_points", ret, r[3]);
        else
            chk("ret_all", ret, (r[3] < ex) ? r[3] : ex);
        if (!r[5]) begin
            // Consecutive words around the trigger differ by n; stop before the
            // newest word so the window never steps onto the oldest
            kmax = (r[2] < 40) ? r[2] : 40;
            kmax = (MEM - r[2] < kmax) ? MEM - r[2] : kmax;
            rd(int'(trig_addr) - 20, a);
            for (int k = -19; k < kmax; k++) begin
                rd(int'(trig_addr) + k, b);
                chk("keep_step", (b - a) & 32'h3fff, r[0]);
                chk("raw_sext", 32'(b[31:14] === {18{b[13]}}), 1);
                a = b;
            end
        end
    endtask

    initial begin
        void'($urandom(32'ha74e2155));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset_done", {busy, done}, 0);
        for (int i = 0; i < 10; i++) begin
            run(tbl[i]);
            $display("test %0d finished, checks %0d", i, num_checks);
        end
        print_verdict;
    end

    // Whole run needs about 30000 cycles
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        print_verdict;
    end
endmodule
